// File: rtl/trng_pkg.sv
// Shared constants of the random byte generator
package trng_pkg;
    // ==================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_START_TRIGGER = 12'h000;
    localparam logic [11:0] OFS_STOP_TRIGGER = 12'h004;
    localparam logic [11:0] OFS_BYTE_READY_FLAG = 12'h100;
    localparam logic [11:0] OFS_EVENT_TASK_LINKS = 12'h200;
    localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h400;
    localparam logic [11:0] OFS_IRQ_STATUS_CLEAR = 12'h404;
    localparam logic [11:0] OFS_GENERATOR_SETTINGS = 12'h504;
    localparam logic [11:0] OFS_RANDOM_OUTPUT = 12'h508;

    // ==================================================
    // Field positions and reset values
    localparam int BIT_TASK = 0;
    localparam int BIT_BYTE_READY = 0;
    localparam int BIT_READY_TO_HALT_LINK = 0;
    localparam int BIT_BIAS_CORRECTION_ENABLE = 0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_LINK = 1'b0;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_BIAS_EN = 1'b0;
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    // ==================================================
    // Bus answers and noise source shape
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] NOISE_LFSR_INIT = 16'hace1;
    localparam logic [1:0] NOISE_GAP_INIT = 2'h1;
endpackage : trng_pkg

// File: rtl/trng_bit_if.sv
// Serial bit stream between noise source, corrector and byte assembly
`timescale 1ns/10ps
interface trng_bit_if;
    logic valid;
    logic bit_val;
    modport src (output valid, output bit_val);
    modport snk (input valid, input bit_val);
endinterface : trng_bit_if

// File: rtl/trng_noise_src.sv
// Free-running noise bit source with irregular bit spacing
`timescale 1ns/10ps
module trng_noise_src import trng_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    trng_bit_if.src raw
);
    typedef struct packed {
        logic [15:0] lfsr;
        logic [1:0] gap;
        logic valid;
        logic bit_val;
    } trng_noise_st_t;

    trng_noise_st_t q, d;

    // ==================================================
    // Next state
    // Shift register runs from reset without software seeding
    always_comb begin
        d = q;
        d.valid = 1'b0;
        d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
        if (q.gap != 2'h0) begin
            d.gap = q.gap - 2'h1;
        end else begin
            // Spacing drawn from the stream, so byte time wanders
            d.gap = q.lfsr[3:2];
            d.valid = run;
            d.bit_val = q.lfsr[0] ^ q.lfsr[7] ^ q.lfsr[11];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{lfsr: NOISE_LFSR_INIT, gap: NOISE_GAP_INIT, valid: 1'b0, bit_val: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign raw.valid = q.valid;
    assign raw.bit_val = q.bit_val;
endmodule : trng_noise_src

// File: rtl/trng_bias_fix.sv
// Pairwise bias corrector, bypassed when correction is off
`timescale 1ns/10ps
module trng_bias_fix import trng_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bias_correction_enable,
    input wire logic run,
    trng_bit_if.snk raw,
    trng_bit_if.src fixed
);
    typedef struct packed {
        logic have_first;
        logic first_bit;
        logic valid;
        logic bit_val;
    } trng_bias_st_t;

    trng_bias_st_t q, d;

    // ==================================================
    // Next state
    always_comb begin
        d = q;
        d.valid = 1'b0;
        if (!run || !bias_correction_enable) begin
            d.have_first = 1'b0;
            d.valid = raw.valid;
            d.bit_val = raw.bit_val;
        end else if (raw.valid) begin
            if (!q.have_first) begin
                d.have_first = 1'b1;
                d.first_bit = raw.bit_val;
            end else begin
                // Equal pairs dropped: removes bias, costs rate
                d.have_first = 1'b0;
                d.valid = q.first_bit ^ raw.bit_val;
                d.bit_val = q.first_bit;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fixed.valid = q.valid;
    assign fixed.bit_val = q.bit_val;
endmodule : trng_bias_fix

// File: rtl/trng_top.sv
// Random byte generator with AXI4-Lite register slave
`timescale 1ns/10ps
module trng_top import trng_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    typedef struct packed {
        logic aw_hold;
        logic [11:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic running;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [7:0] value;
        logic byte_ready;
        logic flag;
        logic link;
        logic irq_en;
        logic bias_en;
    } trng_top_st_t;

    trng_top_st_t q, d;

    trng_bit_if raw_bits ();
    trng_bit_if fixed_bits ();

    // ==================================================
    // Bit path
    trng_noise_src u_noise (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(q.running),
        .raw(raw_bits.src)
    );

    trng_bias_fix u_bias (
        .aclk(aclk),
        .aresetn(aresetn),
        .bias_correction_enable(q.bias_en),
        .run(q.running),
        .raw(raw_bits.snk),
        .fixed(fixed_bits.src)
    );

    // ==================================================
    // Decoding
    function automatic logic reg_known(input logic [11:0] addr);
        unique case (addr)
            OFS_START_TRIGGER, OFS_STOP_TRIGGER, OFS_BYTE_READY_FLAG, OFS_EVENT_TASK_LINKS,
            OFS_IRQ_ENABLE_SET, OFS_IRQ_ENABLE_CLEAR, OFS_IRQ_STATUS, OFS_IRQ_STATUS_CLEAR,
            OFS_GENERATOR_SETTINGS, OFS_RANDOM_OUTPUT: reg_known = 1'b1;
            default: reg_known = 1'b0;
        endcase
    endfunction : reg_known

    function automatic logic [31:0] read_word(input logic [11:0] addr, input trng_top_st_t s);
        read_word = 32'h0000_0000;
        unique case (addr)
            OFS_BYTE_READY_FLAG: read_word[BIT_BYTE_READY] = s.flag;
            OFS_IRQ_STATUS: read_word[BIT_BYTE_READY] = s.flag;
            OFS_EVENT_TASK_LINKS: read_word[BIT_READY_TO_HALT_LINK] = s.link;
            OFS_IRQ_ENABLE_SET, OFS_IRQ_ENABLE_CLEAR: read_word[BIT_BYTE_READY] = s.irq_en;
            OFS_GENERATOR_SETTINGS: read_word[BIT_BIAS_CORRECTION_ENABLE] = s.bias_en;
            OFS_RANDOM_OUTPUT: read_word[7:0] = s.value;
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    // ==================================================
    // Write strobes from held address and data
    logic wr_go;
    logic wr_one;
    logic start_task;
    logic stop_task;
    logic byte_done;

    assign wr_go = q.aw_hold && q.w_hold && !q.bvalid;
    // Only lane 0 carries the control bits
    assign wr_one = q.wstrb[0] && q.wdata[BIT_TASK];
    assign start_task = wr_go && wr_one && (q.awaddr == OFS_START_TRIGGER);
    assign stop_task = wr_go && wr_one && (q.awaddr == OFS_STOP_TRIGGER);
    assign byte_done = q.running && fixed_bits.valid && (q.bit_cnt == BYTE_LAST_BIT);

    // ==================================================
    // Next state
    always_comb begin
        d = q;
        d.byte_ready = 1'b0;

        if (s_axi_awvalid && !q.aw_hold) begin
            d.aw_hold = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_hold) begin
            d.w_hold = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.aw_hold = 1'b0;
            d.w_hold = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = reg_known(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (q.wstrb[0]) begin
                unique case (q.awaddr)
                    OFS_BYTE_READY_FLAG: d.flag = q.wdata[BIT_BYTE_READY];
                    OFS_EVENT_TASK_LINKS: d.link = q.wdata[BIT_READY_TO_HALT_LINK];
                    OFS_IRQ_ENABLE_SET: d.irq_en = q.irq_en | q.wdata[BIT_BYTE_READY];
                    OFS_IRQ_ENABLE_CLEAR: d.irq_en = q.irq_en & ~q.wdata[BIT_BYTE_READY];
                    OFS_IRQ_STATUS_CLEAR: d.flag = q.flag & ~q.wdata[BIT_BYTE_READY];
                    OFS_GENERATOR_SETTINGS: d.bias_en = q.wdata[BIT_BIAS_CORRECTION_ENABLE];
                    default: d.flag = d.flag;
                endcase
            end
        end

        // Reads never disturb generation or the flag
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rdata = read_word(s_axi_araddr, q);
            d.rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Start restarts assembly so a byte never mixes two runs
        if (start_task) begin
            d.running = 1'b1;
            d.bit_cnt = 3'h0;
        end else if (q.running && fixed_bits.valid) begin
            d.shift = {q.shift[6:0], fixed_bits.bit_val};
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (byte_done) begin
                // No overrun guard: an unread byte is simply replaced
                d.value = {q.shift[6:0], fixed_bits.bit_val};
                d.byte_ready = 1'b1;
                d.flag = 1'b1;
            end
        end

        // Stop wins over a start in the same cycle
        if (stop_task || (byte_done && !start_task && q.link)) begin
            d.running = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.flag <= RST_FLAG;
            q.link <= RST_LINK;
            q.irq_en <= RST_IRQ_EN;
            q.bias_en <= RST_BIAS_EN;
            q.value <= RST_VALUE;
        end else begin
            q <= d;
        end
    end

    // ==================================================
    // Outputs
    assign s_axi_awready = !q.aw_hold;
    assign s_axi_wready = !q.w_hold;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign irq = q.flag && q.irq_en;

    // ==================================================
    // Assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_start_write;
        start_task && !stop_task;
    endsequence

    sequence s_stop_write;
        stop_task;
    endsequence

    sequence s_byte_event;
        q.byte_ready;
    endsequence

    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_flag_write;
        wr_go && q.wstrb[0] && q.awaddr == OFS_BYTE_READY_FLAG;
    endsequence

    a_start_runs: assert property (s_start_write |=> q.running)
        else $error("generator not running after start");

    a_stop_halts: assert property (s_stop_write |=> !q.running ##1 !q.byte_ready)
        else $error("generator still active after stop");

    a_byte_once: assert property (s_byte_event |=> !q.byte_ready)
        else $error("byte_ready longer than one cycle");

    a_byte_from_run: assert property (s_byte_event |-> $past(q.running) && $past(q.bit_cnt) == 3'h7)
        else $error("byte stored without eight bits while running");

    a_value_shift: assert property (s_byte_event |-> q.value[7:1] == $past(q.shift[6:0]))
        else $error("output byte does not match assembled bits");

    a_value_holds: assert property (!q.byte_ready |-> $stable(q.value))
        else $error("output changed without byte_ready");

    a_flag_sets: assert property (s_byte_event |-> q.flag)
        else $error("flag not set on byte_ready");

    a_link_stop: assert property (s_byte_event ##0 ($past(q.link) && !$past(start_task)) |-> !q.running)
        else $error("link failed to stop generator");

    a_no_link: assert property (q.byte_ready && !$past(q.link) && !$past(stop_task) |-> q.running)
        else $error("generator stopped without link");

    a_irq_enable: assert property (wr_go && q.awaddr == OFS_IRQ_ENABLE_SET && q.wstrb[0] && q.wdata[0]
        |=> q.irq_en ##0 (irq == q.flag))
        else $error("interrupt not enabled by set write");

    a_irq_disable: assert property (wr_go && q.awaddr == OFS_IRQ_ENABLE_CLEAR && q.wstrb[0] && q.wdata[0]
        |=> !q.irq_en && !irq)
        else $error("interrupt not disabled by clear write");

    a_bias_write: assert property (wr_go && q.awaddr == OFS_GENERATOR_SETTINGS && q.wstrb[0]
        |=> q.bias_en == $past(q.wdata[0]))
        else $error("bias enable does not follow write");

    a_bias_slower: assert property ($past(q.bias_en) && $past(q.running) && fixed_bits.valid
        |-> $past(raw_bits.valid) && $past(u_bias.q.have_first)
        && $past(u_bias.q.first_bit) != $past(raw_bits.bit_val) && fixed_bits.bit_val == $past(u_bias.q.first_bit))
        else $error("corrected bit not from an unequal pair");

    a_read_quiet: assert property (s_axi_arvalid && s_axi_arready && !fixed_bits.valid && !wr_go
        |=> $stable(q.flag))
        else $error("read disturbed flag");

    a_resp_hold: assert property (q.bvalid && !s_axi_bready |=> q.bvalid && $stable(q.bresp))
        else $error("write response dropped early");

    a_write_answer: assert property (wr_go |=> q.bvalid && !q.aw_hold && !q.w_hold)
        else $error("write response missing");

    a_write_unmapped: assert property (wr_go && !reg_known(q.awaddr) |=> q.bresp == RESP_SLVERR)
        else $error("unmapped write answered okay");

    a_read_answer: assert property (s_read_taken |=> q.rvalid)
        else $error("read response missing");

    a_read_hold: assert property (q.rvalid && !s_axi_rready |=> q.rvalid && $stable(q.rdata) && $stable(q.rresp))
        else $error("read response dropped early");

    a_read_unmapped: assert property (s_read_taken ##0 !reg_known(s_axi_araddr)
        |=> q.rdata == 32'h0000_0000 && q.rresp == RESP_SLVERR)
        else $error("unmapped read not refused");

    a_value_read: assert property (s_read_taken ##0 (s_axi_araddr == OFS_RANDOM_OUTPUT)
        |=> q.rdata == {24'h00_0000, $past(q.value)})
        else $error("output read not the stored byte");

    a_flag_clear: assert property (s_flag_write ##0 (!q.wdata[0] && !byte_done) |=> !q.flag)
        else $error("flag not cleared by write");

    a_set_wins: assert property (byte_done && !start_task
        |=> q.flag && q.byte_ready && q.value[0] == $past(fixed_bits.bit_val))
        else $error("completed byte not stored and flagged");

    a_status_clear: assert property (wr_go && q.wstrb[0] && q.wdata[0] && q.awaddr == OFS_IRQ_STATUS_CLEAR
        && !byte_done |=> !q.flag)
        else $error("status clear left flag set");

    a_start_once: assert property (s_start_write |=> !start_task)
        else $error("start task fired twice");

    a_no_self_start: assert property (!q.running && !start_task |=> !q.running)
        else $error("generator started without start task");

    a_link_write: assert property (wr_go && q.wstrb[0] && q.awaddr == OFS_EVENT_TASK_LINKS
        |=> q.link == $past(q.wdata[0]))
        else $error("link bit does not follow write");

    a_bit_step: assert property (q.running && fixed_bits.valid && !start_task
        |=> q.bit_cnt == $past(q.bit_cnt) + 3'h1 && q.shift == {$past(q.shift[6:0]), $past(fixed_bits.bit_val)})
        else $error("bit not shifted into assembly");

    a_enable_zero: assert property (wr_go && q.wstrb[0] && !q.wdata[0]
        && (q.awaddr == OFS_IRQ_ENABLE_SET || q.awaddr == OFS_IRQ_ENABLE_CLEAR) |=> $stable(q.irq_en))
        else $error("zero write changed interrupt enable");

    a_lane_ignored: assert property (wr_go && !q.wstrb[0]
        |=> $stable(q.bias_en) && $stable(q.link) && $stable(q.irq_en))
        else $error("write without lane 0 changed control");
endmodule : trng_top

// File: testbench/tb.sv
// Self-checking bench for the random byte generator register block
`timescale 1ns/10ps
module tb import trng_pkg::*; ;
    logic aclk = 1'b0;
    logic aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] d, v;
    logic link_m, bias_m, en_m;
    logic [11:0] addrs [4];
    int fail_count, total_checks, seed, t_raw, t_bc, idx;
    int cyc = 0;

    trng_top trng_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq));

    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    // ==================================================
    // Reporting
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ==================================================
    // Bus master; ready is sampled mid-cycle, so the handshake edge is the next rising one
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] rsp);
        logic aw_done, w_done, a_rdy, w_rdy;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge aclk);
            a_rdy = s_axi_awready;
            w_rdy = s_axi_wready;
            @(posedge aclk);
            if (!aw_done && a_rdy === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && w_rdy === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] rsp);
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        data = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // ==================================================
    // Expectation model of the control bits
    function automatic logic [31:0] exp_reg(input logic [11:0] addr);
        if (addr == OFS_EVENT_TASK_LINKS) return {31'h0, link_m};
        if (addr == OFS_GENERATOR_SETTINGS) return {31'h0, bias_m};
        return {31'h0, en_m};
    endfunction : exp_reg

    task automatic reg_wr(input logic [11:0] addr, input logic [31:0] data);
        logic [1:0] r;
        axi_write(addr, data, r);
        // A write without lane 0 leaves every control bit alone
        if (s_axi_wstrb[0]) begin
            if (addr == OFS_EVENT_TASK_LINKS) link_m = data[0];
            if (addr == OFS_GENERATOR_SETTINGS) bias_m = data[0];
            if (addr == OFS_IRQ_ENABLE_SET && data[0]) en_m = 1'b1;
            if (addr == OFS_IRQ_ENABLE_CLEAR && data[0]) en_m = 1'b0;
        end
    endtask : reg_wr

    task automatic rd_check(input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] x;
        logic [1:0] r;
        axi_read(addr, x, r);
        check(x, exp);
    endtask : rd_check

    task automatic irq_check(input logic exp);
        @(negedge aclk);
        check({31'h0, irq}, {31'h0, exp});
    endtask : irq_check

    // Polls the flag; the poll period blurs arrival times by a few cycles only
    task automatic wait_flag(input int limit);
        logic [31:0] x;
        logic [1:0] r;
        int n;
        n = 0;
        x = 32'h0;
        while (x[0] !== 1'b1 && n < limit) begin
            axi_read(OFS_BYTE_READY_FLAG, x, r);
            n++;
        end
        check(x, 32'h1);
    endtask : wait_flag

    task automatic time_bytes(output int cycles);
        int t0;
        t0 = cyc;
        reg_wr(OFS_START_TRIGGER, 32'h1);
        repeat (8) begin
            wait_flag(3000);
            reg_wr(OFS_BYTE_READY_FLAG, 32'h0);
        end
        reg_wr(OFS_STOP_TRIGGER, 32'h1);
        cycles = cyc - t0;
    endtask : time_bytes

    // ==================================================
    // Main sequence
    initial begin
        seed = 94424;
        fail_count = 0;
        total_checks = 0;
        {link_m, bias_m, en_m} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_wstrb = 4'hf;
        addrs = '{OFS_EVENT_TASK_LINKS, OFS_GENERATOR_SETTINGS, OFS_IRQ_ENABLE_SET, OFS_IRQ_ENABLE_CLEAR};
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd_check(OFS_BYTE_READY_FLAG, 32'h0);
        rd_check(OFS_EVENT_TASK_LINKS, 32'h0);
        rd_check(OFS_IRQ_ENABLE_SET, 32'h0);
        rd_check(OFS_IRQ_ENABLE_CLEAR, 32'h0);
        rd_check(OFS_GENERATOR_SETTINGS, 32'h0);
        irq_check(1'b0);
        axi_read(12'h0f0, d, resp);
        check(d, 32'h0);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_write(12'h0f0, 32'h1, resp);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        repeat (100) @(posedge aclk);
        rd_check(OFS_BYTE_READY_FLAG, 32'h0);
        // Random control writes while stopped
        repeat (16) begin
            idx = $unsigned($random(seed)) % 4;
            s_axi_wstrb <= 4'($random(seed));
            reg_wr(addrs[idx], $random(seed));
            rd_check(addrs[idx], exp_reg(addrs[idx]));
        end
        s_axi_wstrb <= 4'hf;
        reg_wr(OFS_EVENT_TASK_LINKS, 32'h0);
        reg_wr(OFS_GENERATOR_SETTINGS, 32'h0);
        reg_wr(OFS_IRQ_ENABLE_CLEAR, 32'h1);
        // First byte with no seed, then interrupt masking
        reg_wr(OFS_START_TRIGGER, 32'h1);
        wait_flag(500);
        axi_read(OFS_RANDOM_OUTPUT, v, resp);
        check(v & 32'hffffff00, 32'h0);
        rd_check(OFS_BYTE_READY_FLAG, 32'h1);
        reg_wr(OFS_IRQ_ENABLE_SET, 32'h0);
        irq_check(1'b0);
        reg_wr(OFS_IRQ_ENABLE_SET, 32'h1);
        irq_check(1'b1);
        rd_check(OFS_IRQ_ENABLE_CLEAR, exp_reg(OFS_IRQ_ENABLE_CLEAR));
        reg_wr(OFS_IRQ_ENABLE_CLEAR, 32'h0);
        irq_check(1'b1);
        reg_wr(OFS_IRQ_ENABLE_CLEAR, 32'h1);
        irq_check(1'b0);
        reg_wr(OFS_IRQ_ENABLE_SET, 32'h1);
        rd_check(OFS_IRQ_STATUS, 32'h1);
        reg_wr(OFS_STOP_TRIGGER, 32'h1);
        reg_wr(OFS_IRQ_STATUS_CLEAR, 32'h1);
        rd_check(OFS_BYTE_READY_FLAG, 32'h0);
        irq_check(1'b0);
        // Stop holds: no new byte arrives
        repeat (150) @(posedge aclk);
        rd_check(OFS_BYTE_READY_FLAG, 32'h0);
        // Link from byte_ready to stop, then restart
        reg_wr(OFS_EVENT_TASK_LINKS, 32'h1);
        reg_wr(OFS_START_TRIGGER, 32'h1);
        wait_flag(500);
        axi_read(OFS_RANDOM_OUTPUT, v, resp);
        reg_wr(OFS_BYTE_READY_FLAG, 32'h0);
        repeat (150) @(posedge aclk);
        rd_check(OFS_BYTE_READY_FLAG, 32'h0);
        rd_check(OFS_RANDOM_OUTPUT, v);
        reg_wr(OFS_START_TRIGGER, 32'h1);
        wait_flag(500);
        reg_wr(OFS_EVENT_TASK_LINKS, 32'h0);
        reg_wr(OFS_BYTE_READY_FLAG, 32'h0);
        // Byte rate with and without bias correction
        time_bytes(t_raw);
        reg_wr(OFS_GENERATOR_SETTINGS, 32'h1);
        rd_check(OFS_GENERATOR_SETTINGS, 32'h1);
        time_bytes(t_bc);
        check({31'h0, t_bc > t_raw}, 32'h1);
        summarize();
    end

    // Expected byte times keep the run well below this span; the poll limits alone would allow more
    initial begin
        repeat (90000) @(posedge aclk);
        fail_count++;
        $display("unexpected at %0t: run did not complete", $time);
        summarize();
    end
endmodule : tb
